// ### rtl/tmc_codec.v
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.vh"

module tmc_codec #(
    parameter NIB_W = `TMC_NIB_W,
    parameter FIFO_DEPTH = `TMC_FIFO_DEPTH,
    parameter FIFO_AW = 3
) (
    input wire clock,
    input wire reset,
    input wire speed_10,
    output wire mii_nib_clk,
    input wire mii_tx_en,
    input wire [NIB_W-1:0] mii_txd,
    output wire mii_tx_ready,
    output wire tx_busy,
    output wire mii_rx_dv,
    output wire [NIB_W-1:0] mii_rxd,
    output wire mii_rx_strobe,
    output wire rx_nrz_bit,
    output wire rx_nrz_valid,
    output wire rx_active,
    output wire line_tx_pos,
    output wire line_tx_neg,
    input wire line_rx_pos,
    input wire line_rx_neg,
    input wire mlt3_tx_pos,
    input wire mlt3_tx_neg,
    output wire mlt3_rx_pos,
    output wire mlt3_rx_neg
);

    localparam integer HALF_I = `TMC_HALF_BIT_CYC - 1, NIB_I = `TMC_NIB_HALF_CYC - 1;
    localparam integer GAP_I = `TMC_MID_GAP_CYC - 1, IDLE_I = `TMC_RX_IDLE_CYC;
    localparam [`TMC_CNT_W-1:0] HALF_LAST = HALF_I[`TMC_CNT_W-1:0];
    localparam [`TMC_CNT_W-1:0] NIB_LAST = NIB_I[`TMC_CNT_W-1:0];
    localparam [`TMC_CNT_W-1:0] MID_GAP = GAP_I[`TMC_CNT_W-1:0];
    localparam [`TMC_CNT_W-1:0] RX_IDLE = IDLE_I[`TMC_CNT_W-1:0];
    localparam [`TMC_CNT_W-1:0] CNT_MAX = {`TMC_CNT_W{1'b1}};
    localparam [1:0] LAST_BIT = 2'h3;

    // ****************************************
    // Nibble clock
    // ****************************************
    reg [`TMC_CNT_W-1:0] nib_cnt_r;
    reg nib_clk_r;
    wire nib_stb;

    assign nib_stb = (nib_cnt_r == NIB_LAST) && !nib_clk_r;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            nib_cnt_r <= {`TMC_CNT_W{1'b0}};
            nib_clk_r <= 1'b0;
        end else if (nib_cnt_r == NIB_LAST) begin
            nib_cnt_r <= {`TMC_CNT_W{1'b0}};
            nib_clk_r <= !nib_clk_r;
        end else begin
            nib_cnt_r <= nib_cnt_r + 1'b1;
        end
    end

    assign mii_nib_clk = nib_clk_r;

    // ****************************************
    // Transmit buffer
    // ****************************************
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [NIB_W-1:0] fifo_out_data;
    wire tx_push;
    wire tx_load;

    // nibble port only in 10 Mb/s mode
    // nibble taken at the rising clock edge
    assign tx_push = nib_stb && speed_10 && mii_tx_en;
    assign mii_tx_ready = fifo_in_ready && speed_10;

    tmc_fifo #(
        .WIDTH(NIB_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_tx_fifo (
        .clock(clock),
        .reset(reset),
        .in_valid(tx_push),
        .in_ready(fifo_in_ready),
        .in_data(mii_txd),
        .out_valid(fifo_out_valid),
        .out_ready(tx_load),
        .out_data(fifo_out_data)
    );

    // ****************************************
    // Manchester encoder
    // ****************************************
    reg tx_on_r;
    reg [NIB_W-1:0] tx_sh_r;
    reg [1:0] tx_bits_r;
    reg tx_half_r;
    reg [`TMC_CNT_W-1:0] tx_cnt_r;
    wire half_end;
    wire nib_end;
    wire tx_level;

    assign half_end = tx_on_r && (tx_cnt_r == HALF_LAST);
    assign nib_end = half_end && tx_half_r && (tx_bits_r == LAST_BIT);
    // Refill without a gap so nibbles run back to back
    assign tx_load = fifo_out_valid && (!tx_on_r || nib_end);

    assign tx_level = tx_half_r ? !tx_sh_r[0] : tx_sh_r[0];

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            tx_on_r <= 1'b0;
            tx_sh_r <= {NIB_W{1'b0}};
            tx_bits_r <= 2'h0;
            tx_half_r <= 1'b0;
            tx_cnt_r <= {`TMC_CNT_W{1'b0}};
        end else if (tx_load) begin
            tx_on_r <= 1'b1;
            tx_sh_r <= fifo_out_data;
            tx_bits_r <= 2'h0;
            tx_half_r <= 1'b0;
            tx_cnt_r <= {`TMC_CNT_W{1'b0}};
        end else if (nib_end) begin
            tx_on_r <= 1'b0;
        end else if (half_end) begin
            tx_cnt_r <= {`TMC_CNT_W{1'b0}};
            tx_half_r <= !tx_half_r;
            if (tx_half_r) begin
                tx_sh_r <= {1'b0, tx_sh_r[NIB_W-1:1]};
                tx_bits_r <= tx_bits_r + 1'b1;
            end
        end else if (tx_on_r) begin
            tx_cnt_r <= tx_cnt_r + 1'b1;
        end
    end

    assign tx_busy = tx_on_r;

    // ****************************************
    // Line transmit pair
    // ****************************************
    reg line_tx_pos_r;
    reg line_tx_neg_r;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            line_tx_pos_r <= 1'b0;
            line_tx_neg_r <= 1'b0;
        end else if (!speed_10) begin
            line_tx_pos_r <= mlt3_tx_pos;
            line_tx_neg_r <= mlt3_tx_neg;
        end else begin
            // Idle pair sits at zero difference
            line_tx_pos_r <= tx_on_r && tx_level;
            line_tx_neg_r <= tx_on_r && !tx_level;
        end
    end

    assign line_tx_pos = line_tx_pos_r;
    assign line_tx_neg = line_tx_neg_r;

    // ****************************************
    // Line receive pair
    // ****************************************
    reg rx_pos_m_r;
    reg rx_neg_m_r;
    reg rx_pos_s_r;
    reg rx_neg_s_r;
    reg mlt3_rx_pos_r;
    reg mlt3_rx_neg_r;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_pos_m_r <= 1'b0;
            rx_neg_m_r <= 1'b0;
            rx_pos_s_r <= 1'b0;
            rx_neg_s_r <= 1'b0;
            mlt3_rx_pos_r <= 1'b0;
            mlt3_rx_neg_r <= 1'b0;
        end else begin
            rx_pos_m_r <= line_rx_pos;
            rx_neg_m_r <= line_rx_neg;
            rx_pos_s_r <= rx_pos_m_r;
            rx_neg_s_r <= rx_neg_m_r;
            mlt3_rx_pos_r <= !speed_10 && rx_pos_s_r;
            mlt3_rx_neg_r <= !speed_10 && rx_neg_s_r;
        end
    end

    assign mlt3_rx_pos = mlt3_rx_pos_r;
    assign mlt3_rx_neg = mlt3_rx_neg_r;

    // ****************************************
    // Manchester decoder
    // ****************************************
    reg rx_lvl_r;
    reg rx_on_r;
    reg rx_arm_r;
    reg [`TMC_CNT_W-1:0] rx_cnt_r;
    reg [NIB_W-1:0] rx_sh_r;
    reg [1:0] rx_bits_r;
    reg rx_bit_r;
    reg rx_bit_vld_r;
    reg [NIB_W-1:0] rxd_r;
    reg rx_dv_r;
    reg rx_stb_r;
    wire rx_now;
    wire rx_edge;
    wire mid_edge;
    wire new_bit;

    // Differential level: positive leg high and negative leg low
    assign rx_now = rx_pos_s_r && !rx_neg_s_r;
    assign rx_edge = speed_10 && (rx_now != rx_lvl_r);
    // timing locks on first edges, then re-times each bit
    assign mid_edge = rx_on_r && rx_edge && (rx_arm_r || rx_cnt_r >= MID_GAP);
    // bit value is the first-half level
    assign new_bit = !rx_now;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_lvl_r <= 1'b0;
            rx_on_r <= 1'b0;
            rx_arm_r <= 1'b0;
            rx_cnt_r <= {`TMC_CNT_W{1'b0}};
            rx_sh_r <= {NIB_W{1'b0}};
            rx_bits_r <= 2'h0;
            rx_bit_r <= 1'b0;
            rx_bit_vld_r <= 1'b0;
            rxd_r <= {NIB_W{1'b0}};
            rx_dv_r <= 1'b0;
            rx_stb_r <= 1'b0;
        end else begin
            rx_lvl_r <= rx_now;
            rx_bit_vld_r <= 1'b0;
            rx_stb_r <= 1'b0;
            if (!rx_on_r) begin
                if (rx_edge) begin
                    // First edge is a bit boundary; the next is mid-bit
                    rx_on_r <= 1'b1;
                    rx_arm_r <= 1'b1;
                    rx_cnt_r <= {`TMC_CNT_W{1'b0}};
                    rx_bits_r <= 2'h0;
                end
            end else if (mid_edge) begin
                rx_arm_r <= 1'b0;
                rx_cnt_r <= {`TMC_CNT_W{1'b0}};
                rx_bit_r <= new_bit;
                rx_bit_vld_r <= 1'b1;
                rx_sh_r <= {new_bit, rx_sh_r[NIB_W-1:1]};
                rx_bits_r <= rx_bits_r + 1'b1;
                if (rx_bits_r == LAST_BIT) begin
                    rxd_r <= {new_bit, rx_sh_r[NIB_W-1:1]};
                    rx_dv_r <= 1'b1;
                    rx_stb_r <= 1'b1;
                end
            end else if (rx_cnt_r >= RX_IDLE || !speed_10) begin
                // Partial trailing nibble is dropped
                rx_on_r <= 1'b0;
                rx_arm_r <= 1'b0;
                rx_dv_r <= 1'b0;
                rx_bits_r <= 2'h0;
            end else if (rx_cnt_r != CNT_MAX) begin
                rx_cnt_r <= rx_cnt_r + 1'b1;
            end
        end
    end

    assign rx_nrz_bit = rx_bit_r;
    assign rx_nrz_valid = rx_bit_vld_r;
    assign rx_active = rx_on_r;
    assign mii_rxd = rxd_r;
    assign mii_rx_dv = rx_dv_r;
    assign mii_rx_strobe = rx_stb_r;

endmodule // tmc_codec

`default_nettype wire

// ### rtl/tmc_defines.vh
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

// ****************************************
// Clock and line timing
// ****************************************
`define TMC_CLK_PERIOD_NS 5
// Half of a 100 ns Manchester bit
`define TMC_HALF_BIT_NS 50
`define TMC_HALF_BIT_CYC ((`TMC_HALF_BIT_NS + `TMC_CLK_PERIOD_NS - 1) / `TMC_CLK_PERIOD_NS)
// Half period of the 2.5 MHz nibble clock
`define TMC_NIB_HALF_NS 200
`define TMC_NIB_HALF_CYC ((`TMC_NIB_HALF_NS + `TMC_CLK_PERIOD_NS - 1) / `TMC_CLK_PERIOD_NS)
// Least gap between two mid-bit edges (three quarters of a bit)
`define TMC_MID_GAP_NS 75
`define TMC_MID_GAP_CYC ((`TMC_MID_GAP_NS + `TMC_CLK_PERIOD_NS - 1) / `TMC_CLK_PERIOD_NS)
// Silence that ends a received frame (one and a half bits)
`define TMC_RX_IDLE_NS 150
`define TMC_RX_IDLE_CYC (`TMC_RX_IDLE_NS / `TMC_CLK_PERIOD_NS)

// ****************************************
// Datapath shapes
// ****************************************
`define TMC_NIB_W 4
`define TMC_FIFO_DEPTH 8
`define TMC_CNT_W 6

`endif

// ### rtl/tmc_fifo.v
`timescale 1ns/1ps
`default_nettype none

module tmc_fifo #(
    parameter WIDTH = 4,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clock,
    input wire reset,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_r;
    reg [AW-1:0] rd_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    // Wrap works for any depth up to two to the AW
    function [AW-1:0] ptr_next;
        input [AW-1:0] ptr;
        ptr_next = (ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : ptr + 1'b1;
    endfunction

    assign in_ready = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clock) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_r <= {AW{1'b0}};
            rd_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_r <= ptr_next(wr_r);
            end
            if (pop) begin
                rd_r <= ptr_next(rd_r);
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule // tmc_fifo

`default_nettype wire

// ### tb/tmc_codec_props.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_codec_props (
    input wire logic clock,
    input wire logic reset,
    input wire logic speed_10,
    input wire logic mii_nib_clk,
    input wire logic mii_tx_ready,
    input wire logic mii_rx_dv,
    input wire logic mii_rx_strobe,
    input wire logic rx_nrz_valid,
    input wire logic rx_active,
    input wire logic line_tx_pos,
    input wire logic line_tx_neg,
    input wire logic mlt3_tx_pos,
    input wire logic mlt3_tx_neg
);
    // ****
    // Checks
    // ****
    logic nib_q_r, seen_r;
    logic [7:0] half_r;
    wire logic nib_chg = mii_nib_clk != nib_q_r;
    wire logic [1:0] pair = {line_tx_pos, line_tx_neg};
    // First half period after reset is not judged
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            nib_q_r <= 1'b0;
            seen_r <= 1'b0;
            half_r <= 8'h00;
        end else begin
            nib_q_r <= mii_nib_clk;
            seen_r <= seen_r | nib_chg;
            half_r <= nib_chg ? 8'h00 : half_r + 8'h01;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_nib_half:
    assert property (nib_chg && seen_r |-> half_r == 8'h27) else $error("nibble clock half");
    a_ready_mode:
    assert property (!speed_10 |-> !mii_tx_ready) else $error("ready in 100M");
    a_mlt3_copy:
    assert property (!speed_10 && !$past(speed_10) && !$past(reset)
        |-> pair == $past({mlt3_tx_pos, mlt3_tx_neg})) else $error("tx pair not copied");
    a_pair_legal:
    assert property (speed_10 && $past(speed_10) |-> pair != 2'b11) else $error("tx pair both high");
    a_half_hold:
    assert property ($changed(pair) && pair != 2'b00 && speed_10 && $past(speed_10)
        |=> $stable(pair)[*8]) else $error("half bit too short");
    a_strobe_gap:
    assert property (mii_rx_strobe |=> !mii_rx_strobe[*8]) else $error("strobe too long");
    a_nrz_gap:
    assert property (rx_nrz_valid |=> !rx_nrz_valid[*8]) else $error("bit pulse too long");
    a_strobe_frame:
    assert property (mii_rx_strobe |-> mii_rx_dv && rx_active) else $error("strobe off frame");
    a_mode_rx:
    assert property (!speed_10 && !$past(speed_10) |-> !mii_rx_dv) else $error("dv in 100M");
    c_nibble: cover property (mii_rx_strobe);
    c_tx_line: cover property (speed_10 && $rose(line_tx_pos));
    c_mlt3: cover property (!speed_10 && line_tx_neg);
endmodule // tmc_codec_props
bind tmc_codec tmc_codec_props u_props (
    .clock(clock), .reset(reset), .speed_10(speed_10), .mii_nib_clk(mii_nib_clk),
    .mii_tx_ready(mii_tx_ready), .mii_rx_dv(mii_rx_dv), .mii_rx_strobe(mii_rx_strobe),
    .rx_nrz_valid(rx_nrz_valid), .rx_active(rx_active), .line_tx_pos(line_tx_pos),
    .line_tx_neg(line_tx_neg), .mlt3_tx_pos(mlt3_tx_pos), .mlt3_tx_neg(mlt3_tx_neg)
);
`default_nettype wire

// ### tb/tmc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_line_model (
    output logic line_rx_pos,
    output logic line_rx_neg
);
    // ****
    // Remote line driver
    // ****
    initial {line_rx_pos, line_rx_neg} = 2'b00;
    task automatic hold(input logic [1:0] v);
        {line_rx_pos, line_rx_neg} = v;
    endtask
    // Bit time is two halves; slow partners stretch it, fast ones shrink it
    task automatic send(input logic [31:0] w, input int nb, input int half);
        for (int i = 0; i < nb; i++) begin
            {line_rx_pos, line_rx_neg} = w[i] ? 2'b10 : 2'b01;
            #(half);
            {line_rx_pos, line_rx_neg} = w[i] ? 2'b01 : 2'b10;
            #(half);
        end
        // Released line goes idle, not the last level
        hold(2'b00);
    endtask
endmodule // tmc_line_model
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 1'b0, reset = 1'b1, speed_10 = 1'b1, mii_tx_en = 1'b0;
    logic mlt3_tx_pos = 1'b0, mlt3_tx_neg = 1'b0, h;
    logic [3:0] mii_txd = 4'h0, nib, txq[$], rxq[$];
    logic bq[$];
    logic [31:0] lfsr = 32'h82b10be6;
    int fail_count = 0, n_tests = 0;
    wire mii_nib_clk, mii_tx_ready, tx_busy, mii_rx_dv, mii_rx_strobe, rx_nrz_bit, rx_active;
    wire rx_nrz_valid, line_tx_pos, line_tx_neg, line_rx_pos, line_rx_neg, mlt3_rx_pos;
    wire mlt3_rx_neg;
    wire [3:0] mii_rxd;
    tmc_codec uut (
        .clock(clock), .reset(reset), .speed_10(speed_10), .mii_nib_clk(mii_nib_clk),
        .mii_tx_en(mii_tx_en), .mii_txd(mii_txd), .mii_tx_ready(mii_tx_ready),
        .tx_busy(tx_busy), .mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd),
        .mii_rx_strobe(mii_rx_strobe), .rx_nrz_bit(rx_nrz_bit), .rx_nrz_valid(rx_nrz_valid),
        .rx_active(rx_active), .line_tx_pos(line_tx_pos), .line_tx_neg(line_tx_neg),
        .line_rx_pos(line_rx_pos), .line_rx_neg(line_rx_neg), .mlt3_tx_pos(mlt3_tx_pos),
        .mlt3_tx_neg(mlt3_tx_neg), .mlt3_rx_pos(mlt3_rx_pos), .mlt3_rx_neg(mlt3_rx_neg)
    );
    tmc_line_model lp (.line_rx_pos(line_rx_pos), .line_rx_neg(line_rx_neg));
    always #2.5 clock = ~clock;
    // ****
    // Tasks
    // ****
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_nib({3'h0, got}, {3'h0, exp});
    endtask
    task automatic close_out();
        $display("compares=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tx_frame(input int nn);
        for (int i = 0; i < nn; i++) begin
            @(negedge clock);
            lfsr = nxt(lfsr);
            mii_tx_en = 1'b1;
            mii_txd = lfsr[3:0];
            if (mii_tx_ready === 1'b1)
                txq.push_back(lfsr[3:0]);
            @(posedge mii_nib_clk);
        end
        @(negedge clock);
        mii_tx_en = 1'b0;
    endtask
    task automatic tx_drain();
        for (int k = 0; k < 400 && tx_busy !== 1'b0; k++)
            @(negedge clock);
        chk_bit(tx_busy, 1'b0);
        repeat (30) @(negedge clock);
    endtask
    // Frames open with a one: the decoder arms on the first edge
    task automatic rx_frame(input int nb, input int half);
        logic [31:0] w;
        lfsr = nxt(lfsr);
        w = lfsr | 32'h1;
        for (int i = 0; i < nb; i++) begin
            bq.push_back(w[i]);
            if (i % 4 == 3)
                rxq.push_back(w[i-3 +: 4]);
        end
        lp.send(w, nb, half);
        repeat (60) @(negedge clock);
        chk_bit(mii_rx_dv, 1'b0);
    endtask
    task automatic mode100();
        @(negedge clock);
        speed_10 = 1'b0;
        mii_tx_en = 1'b1;
        repeat (30) begin
            @(negedge clock);
            lfsr = nxt(lfsr);
            {mlt3_tx_pos, mlt3_tx_neg} = lfsr[1:0];
            mii_txd = lfsr[5:2];
            lp.hold(lfsr[7:6]);
            repeat (6) @(negedge clock);
            chk_nib({line_tx_pos, line_tx_neg, mlt3_rx_pos, mlt3_rx_neg},
                {lfsr[1:0], lfsr[7:6]});
            chk_bit(mii_tx_ready, 1'b0);
        end
        {mlt3_tx_pos, mlt3_tx_neg} = 2'b00;
        lp.hold(2'b00);
        mii_tx_en = 1'b0;
        repeat (10) @(negedge clock);
        speed_10 = 1'b1;
        repeat (100) @(negedge clock);
    endtask
    // ****
    // Monitors
    // ****
    always @(negedge clock) begin
        if (mii_rx_strobe === 1'b1)
            chk_nib(mii_rxd, rxq.size() ? rxq.pop_front() : 4'hx);
        if (rx_nrz_valid === 1'b1)
            chk_bit(rx_nrz_bit, bq.size() ? bq.pop_front() : 1'bx);
    end
    // Halves sampled on their first cycle, then ten cycles on
    always begin
        @(negedge clock);
        while (speed_10 && (line_tx_pos || line_tx_neg)) begin
            for (int b = 0; b < 4; b++) begin
                h = line_tx_pos;
                repeat (10) @(negedge clock);
                chk_bit(line_tx_pos, !h);
                nib[b] = h;
                repeat (10) @(negedge clock);
            end
            chk_nib(nib, txq.size() ? txq.pop_front() : 4'hx);
        end
    end
    // ****
    // Sequence
    // ****
    initial begin
        repeat (20) @(negedge clock);
        reset = 1'b0;
        fork
            tx_frame(6);
            rx_frame(32, 50);
        join
        tx_drain();
        $display("test nominal done");
        rx_frame(20, 55);
        rx_frame(10, 50);
        $display("test slow and partial done");
        mode100();
        $display("test mode switch done");
        fork
            tx_frame(3);
            rx_frame(12, 45);
        join
        tx_drain();
        chk_bit(txq.size() + rxq.size() + bq.size() == 0, 1'b1);
        $display("test return done");
        close_out();
    end
    // Several times the expected run
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
endmodule // tb
`default_nettype wire
